// >>> verilog/scp_engine.sv
// Cam profile engine: turns the cam axis one-cycle position into a feed position.
// Assumes configuration inputs are static on CLOCK_IN; pins are asynchronous.
//
// Notes on behaviour
// - Stroke mode: feed = reference + stroke times table ratio at cycle position.
// - Coordinate mode: feed = reference + list output at cycle position.
// - Between profile points the value is interpolated from neighbours.
// - Stroke tables: 256/512/1024/2048 entries, ratios clamped to +-100.000 %.
// - Coordinate lists: 2 to 1024 points, inputs clamped to 0..999999.
// - Coordinate outputs signed, clamped to +-999999, carried in 32 bits.
// - 8 Kbyte storage area copied after reset into 8 Kbyte working area.
// - Working area writes only while servo is off and the boot copy is done; others are refused.
// - Twelve selectable curve shapes form the interpolation between points.
// - Encoder following: A/B quadrature count drives the cam axis.
// - Encoder input up to 4 Mpulses/s; edges closer than 3 cycles raise an error.
// - One mark input; an event registers on its rising edge.
// - Each mark yields a compensation added to the feed position.
`timescale 1ns/10ps
`default_nettype none

module scp_engine import scp_pkg::*; (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  // Configuration and axis input
  input wire scp_cfg_s CAM_CFG_IN,
  input wire logic [31:0] CMD_POS_IN,
  input wire logic SERVO_ON_IN,
  // Profile writes
  input wire scp_wr_s WORK_WR_IN,
  input wire scp_wr_s STORE_WR_IN,
  // Pins
  input wire logic ENC_A_IN,
  input wire logic ENC_B_IN,
  input wire logic MARK_IN,
  // Results
  output logic signed [31:0] FEED_POS_OUT,
  output logic FEED_VALID_OUT,
  output logic [31:0] CYCLE_POS_OUT,
  output logic BOOT_BUSY_OUT,
  output logic WR_REFUSED_OUT,
  output logic MARK_EVENT_OUT,
  output logic signed [31:0] MARK_COMP_OUT,
  output logic ENC_ERR_OUT,
  output logic [31:0] ENC_COUNT_OUT
);

  typedef enum logic [3:0] {
    ST_BOOT, ST_IDLE, ST_SEEK0, ST_SEEK1, ST_SEEK2,
    ST_DIV, ST_RD0, ST_RD1, ST_RD2, ST_CALC
  } scp_state_e;

  // ==========================================================================
  // Helpers
  function automatic logic signed [31:0] clamp_s(input logic signed [31:0] v,
                                                 input logic signed [31:0] lim);
    if (v > lim) return lim;
    if (v < -lim) return -lim;
    return v;
  endfunction : clamp_s

  function automatic logic [8:0] curve_pt(input logic [3:0] c, input logic [3:0] k);
    logic [3:0] ci;
    ci = (c > 4'(CURVE_COUNT - 1)) ? 4'h0 : c;
    return CURVE_TAB[ci][k];
  endfunction : curve_pt

  function automatic logic [8:0] curve_map(input logic [3:0] c, input logic [8:0] f);
    logic [8:0] a;
    logic [8:0] b;
    logic [13:0] p;
    a = curve_pt(c, {1'b0, f[7:5]});
    b = curve_pt(c, {1'b0, f[7:5]} + 4'h1);
    p = 14'(b - a) * 14'(f[4:0]);
    if (f[8]) return FRAC_ONE;
    return 9'(14'(a) + (p >> 5));
  endfunction : curve_map

  // ==========================================================================
  // Declarations
  scp_state_e st_q, st_d;
  logic [BOOT_W-1:0] boot_q, boot_d;
  logic [31:0] x_q, x_d;
  logic [SEG_W-1:0] seg_q, seg_d;
  logic [MEM_AW-1:0] idx_q, idx_d;
  logic [COORD_IN_W-1:0] in0_q, in0_d;
  logic [32:0] rem_q, rem_d, den_q, den_d;
  logic [QUO_W-1:0] quo_q, quo_d;
  logic [4:0] dcnt_q, dcnt_d;
  logic [8:0] frac_q, frac_d;
  logic signed [31:0] p0_q, p0_d, p1_q, p1_d, feed_q, feed_d;
  logic valid_q, valid_d, refused_q, refused_d, busy_q, busy_d;
  logic [MEM_DW-1:0] work_rdata, stor_rdata, wdata;
  logic [MEM_AW-1:0] raddr, waddr, stor_raddr;
  logic wr_en;
  logic [31:0] enc_count, cyc_q, cyc_d, prev_q, prev_d, len_eff;
  logic primed_q, primed_d;
  logic m1_q, m2_q, m3_q, mark_ev_q, mark_ev_d;
  logic signed [31:0] comp_q, comp_d;
  logic [NPTS_W-1:0] npts;
  logic [SEG_W-1:0] seg_last;
  logic [11:0] res_n;

  assign len_eff = (CAM_CFG_IN.cycle_len == 32'h0) ? 32'h1 : CAM_CFG_IN.cycle_len;
  assign npts = (CAM_CFG_IN.n_points < NPTS_W'(COORD_MIN)) ? NPTS_W'(COORD_MIN) :
                (CAM_CFG_IN.n_points > NPTS_W'(COORD_MAX)) ? NPTS_W'(COORD_MAX) :
                CAM_CFG_IN.n_points;
  assign seg_last = SEG_W'(npts - NPTS_W'(COORD_MIN));
  assign res_n = 12'(RES_MIN) << CAM_CFG_IN.res_sel;

  // ==========================================================================
  // Storage area, working area and quadrature decoder
  scp_mem #(.DW(MEM_DW), .AW(MEM_AW)) u_store (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .we_in(STORE_WR_IN.we),
    .waddr_in(STORE_WR_IN.addr),
    .wdata_in(STORE_WR_IN.data),
    .raddr_in(stor_raddr),
    .rdata_out(stor_rdata)
  );

  scp_mem #(.DW(MEM_DW), .AW(MEM_AW)) u_work (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .we_in(wr_en),
    .waddr_in(waddr),
    .wdata_in(wdata),
    .raddr_in(raddr),
    .rdata_out(work_rdata)
  );

  scp_quad #(.CNT_W(32), .MIN_GAP(ENC_EDGE_CYC_MIN)) u_quad (
    .clk_in(CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .a_in(ENC_A_IN),
    .b_in(ENC_B_IN),
    .count_out(enc_count),
    .err_out(ENC_ERR_OUT)
  );

  assign ENC_COUNT_OUT = enc_count;

  // ==========================================================================
  // One-cycle position and mark compensation
  always_comb begin
    logic [31:0] src;
    logic signed [33:0] sum;
    src = CAM_CFG_IN.src_internal ? CMD_POS_IN : enc_count;
    sum = $signed({2'b00, cyc_q}) + 34'($signed(src - prev_q));
    // Only one wrap per cycle: the axis may not move a whole cycle per clock
    if (sum < 34'sh0) begin
      sum = sum + $signed({2'b00, len_eff});
    end else if (sum >= $signed({2'b00, len_eff})) begin
      sum = sum - $signed({2'b00, len_eff});
    end
    prev_d = src;
    primed_d = 1'b1;
    cyc_d = primed_q ? sum[31:0] : cyc_q;
    if (cyc_d >= len_eff) begin
      cyc_d = 32'h0;
    end
    mark_ev_d = m2_q & ~m3_q;
    comp_d = comp_q;
    if (mark_ev_d) begin
      comp_d = $signed(CAM_CFG_IN.mark_target - cyc_q);
    end
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cyc_q <= 32'h0;
      prev_q <= 32'h0;
      primed_q <= 1'b0;
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      m3_q <= 1'b0;
      mark_ev_q <= 1'b0;
      comp_q <= 32'sh0;
    end else begin
      cyc_q <= cyc_d;
      prev_q <= prev_d;
      primed_q <= primed_d;
      m1_q <= MARK_IN;
      m2_q <= m1_q;
      m3_q <= m2_q;
      mark_ev_q <= mark_ev_d;
      comp_q <= comp_d;
    end
  end

  // ==========================================================================
  // Boot copy and conversion sequencer
  always_comb begin
    logic [COORD_IN_W-1:0] in1;
    logic [32:0] rsh;
    logic [QUO_W-1:0] qn;
    logic [QUO_W-1:0] qs;
    logic signed [39:0] d40, mix, sfx;
    logic signed [79:0] prod;
    logic signed [31:0] cam_val;
    in1 = (work_rdata > COORD_IN_MAX) ? COORD_IN_MAX[COORD_IN_W-1:0] :
          work_rdata[COORD_IN_W-1:0];
    rsh = {rem_q[31:0], 1'b0};
    qn = {quo_q[QUO_W-2:0], rsh >= den_q};
    qs = qn >> (2'(RES_SEL_MAX) - CAM_CFG_IN.res_sel);
    sfx = $signed({31'h0, curve_map(CAM_CFG_IN.curve, frac_q)});
    d40 = 40'(p1_q) - 40'(p0_q);
    mix = 40'(p0_q) + ((d40 * sfx) >>> FRAC_W);
    prod = 80'($signed(CAM_CFG_IN.stroke)) * 80'(mix) * 80'(RATIO_RECIP);
    cam_val = (CAM_CFG_IN.mode == MODE_STROKE) ? 32'(prod >>> RATIO_SHIFT) : 32'(mix);
    st_d = st_q;
    boot_d = boot_q;
    x_d = x_q;
    seg_d = seg_q;
    idx_d = idx_q;
    in0_d = in0_q;
    rem_d = rem_q;
    den_d = den_q;
    quo_d = quo_q;
    dcnt_d = dcnt_q;
    frac_d = frac_q;
    p0_d = p0_q;
    p1_d = p1_q;
    feed_d = feed_q;
    valid_d = 1'b0;
    refused_d = 1'b0;
    wr_en = 1'b0;
    waddr = WORK_WR_IN.addr;
    wdata = WORK_WR_IN.data;
    raddr = '0;
    stor_raddr = '0;
    if (WORK_WR_IN.we) begin
      if (SERVO_ON_IN || st_q == ST_BOOT) begin
        refused_d = 1'b1;
      end else begin
        wr_en = 1'b1;
      end
    end
    case (st_q)
      ST_BOOT: begin
        stor_raddr = boot_q[MEM_AW-1:0];
        boot_d = boot_q + 1'b1;
        if (boot_q != '0) begin
          wr_en = 1'b1;
          waddr = MEM_AW'(boot_q - 1'b1);
          wdata = stor_rdata;
        end
        if (boot_q == BOOT_W'(MEM_WORDS)) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        x_d = cyc_q;
        rem_d = {1'b0, cyc_q};
        den_d = {1'b0, len_eff};
        quo_d = '0;
        dcnt_d = 5'h0;
        if (seg_q > seg_last) begin
          seg_d = '0;
        end
        st_d = (CAM_CFG_IN.mode == MODE_STROKE) ? ST_DIV : ST_SEEK0;
      end
      ST_SEEK0: begin
        raddr = {seg_q, 1'b0};
        st_d = ST_SEEK1;
      end
      ST_SEEK1: begin
        raddr = MEM_AW'({seg_q, 1'b0} + 11'h2);
        in0_d = in1;
        st_d = ST_SEEK2;
      end
      ST_SEEK2: begin
        // Walk one segment at a time; the position moves little between runs
        if (x_q < 32'(in0_q) && seg_q != '0) begin
          seg_d = seg_q - 1'b1;
          st_d = ST_SEEK0;
        end else if (x_q >= 32'(in1) && seg_q < seg_last) begin
          seg_d = seg_q + 1'b1;
          st_d = ST_SEEK0;
        end else if (x_q < 32'(in0_q) || in1 <= in0_q) begin
          frac_d = 9'h000;
          st_d = ST_RD0;
        end else if (x_q >= 32'(in1)) begin
          frac_d = FRAC_ONE;
          st_d = ST_RD0;
        end else begin
          rem_d = 33'(x_q - 32'(in0_q));
          den_d = 33'(in1 - in0_q);
          st_d = ST_DIV;
        end
      end
      ST_DIV: begin
        rem_d = (rsh >= den_q) ? rsh - den_q : rsh;
        quo_d = qn;
        dcnt_d = dcnt_q + 5'h1;
        if (dcnt_q == 5'(QUO_W - 1)) begin
          idx_d = qs[QUO_W-1:FRAC_W];
          frac_d = (CAM_CFG_IN.mode == MODE_STROKE) ? {1'b0, qs[FRAC_W-1:0]} :
                   {1'b0, qn[QUO_W-1:QUO_W-FRAC_W]};
          st_d = ST_RD0;
        end
      end
      ST_RD0: begin
        raddr = (CAM_CFG_IN.mode == MODE_STROKE) ? idx_q : {seg_q, 1'b1};
        st_d = ST_RD1;
      end
      ST_RD1: begin
        // The stroke table is cyclic: the last entry blends into the first
        raddr = (CAM_CFG_IN.mode == MODE_STROKE) ?
                ((idx_q + 1'b1) & MEM_AW'(res_n - 12'h1)) :
                MEM_AW'({seg_q, 1'b1} + 11'h2);
        p0_d = (CAM_CFG_IN.mode == MODE_STROKE) ? clamp_s(work_rdata, RATIO_MAX) :
               clamp_s(work_rdata, COORD_OUT_MAX);
        st_d = ST_RD2;
      end
      ST_RD2: begin
        p1_d = (CAM_CFG_IN.mode == MODE_STROKE) ? clamp_s(work_rdata, RATIO_MAX) :
               clamp_s(work_rdata, COORD_OUT_MAX);
        st_d = ST_CALC;
      end
      ST_CALC: begin
        feed_d = CAM_CFG_IN.ref_pos + cam_val + comp_q;
        valid_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    busy_d = (st_d == ST_BOOT);
  end

  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q <= ST_BOOT;
      boot_q <= '0;
      x_q <= 32'h0;
      seg_q <= '0;
      idx_q <= '0;
      in0_q <= '0;
      rem_q <= '0;
      den_q <= 33'h1;
      quo_q <= '0;
      dcnt_q <= 5'h0;
      frac_q <= 9'h000;
      p0_q <= 32'sh0;
      p1_q <= 32'sh0;
      feed_q <= 32'sh0;
      valid_q <= 1'b0;
      refused_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      boot_q <= boot_d;
      x_q <= x_d;
      seg_q <= seg_d;
      idx_q <= idx_d;
      in0_q <= in0_d;
      rem_q <= rem_d;
      den_q <= den_d;
      quo_q <= quo_d;
      dcnt_q <= dcnt_d;
      frac_q <= frac_d;
      p0_q <= p0_d;
      p1_q <= p1_d;
      feed_q <= feed_d;
      valid_q <= valid_d;
      refused_q <= refused_d;
      busy_q <= busy_d;
    end
  end

  assign FEED_POS_OUT = feed_q;
  assign FEED_VALID_OUT = valid_q;
  assign CYCLE_POS_OUT = cyc_q;
  assign BOOT_BUSY_OUT = busy_q;
  assign WR_REFUSED_OUT = refused_q;
  assign MARK_EVENT_OUT = mark_ev_q;
  assign MARK_COMP_OUT = comp_q;

endmodule : scp_engine
`default_nettype wire

// >>> verilog/scp_pkg.sv
// Shared constants, types and tables of the cam profile engine.
// Assumes a single 50 MHz clock domain; every user file imports scp_pkg::*.

package scp_pkg;

  // ==========================================================================
  // Clock and encoder timing
  localparam int CLK_PERIOD_PS = 20000;
  // Fastest legal quadrature input, pulses per second
  localparam int ENC_MAX_PPS = 4000000;
  // Four decoded edges per pulse, so the closest edge spacing in picoseconds
  localparam int ENC_EDGE_PS = 1000000000 / (ENC_MAX_PPS / 1000) / 4;
  // Shortest edge spacing in cycles that is still accepted: round down, at least one cycle
  localparam int ENC_EDGE_CYC_MIN = (ENC_EDGE_PS / CLK_PERIOD_PS < 1) ? 1 :
                                    ENC_EDGE_PS / CLK_PERIOD_PS;
  localparam int GAP_W = 4;

  // ==========================================================================
  // Profile memories: 8 Kbytes each, held as 32-bit words
  localparam int MEM_BYTES = 8192;
  localparam int MEM_DW = 32;
  localparam int MEM_WORDS = MEM_BYTES / (MEM_DW / 8);
  localparam int MEM_AW = $clog2(MEM_WORDS);
  localparam int BOOT_W = MEM_AW + 1;

  // ==========================================================================
  // Stroke-ratio tables
  localparam int RES_MIN = 256;
  localparam int RES_SEL_MAX = 3;
  localparam int FRAC_W = 8;
  localparam int QUO_W = MEM_AW + FRAC_W;
  localparam logic [8:0] FRAC_ONE = 9'h100;
  // Ratio entries in units of 0.001 percent
  localparam logic signed [31:0] RATIO_MAX = 32'sh000186A0;
  // Division by 100000 done as a multiply by 2^37 / 100000
  localparam logic signed [31:0] RATIO_RECIP = 32'sh0014F8B6;
  localparam int RATIO_SHIFT = 37;

  // ==========================================================================
  // Coordinate lists: word 2i is the input of point i, word 2i+1 its output
  localparam int COORD_MIN = 2;
  localparam int COORD_MAX = 1024;
  localparam int COORD_IN_W = 20;
  localparam int SEG_W = 10;
  localparam int NPTS_W = 11;
  localparam logic [31:0] COORD_IN_MAX = 32'h000F423F;
  localparam logic signed [31:0] COORD_OUT_MAX = 32'sh000F423F;

  // ==========================================================================
  // Modes and curve shapes
  typedef enum logic {
    MODE_STROKE,
    MODE_COORD
  } scp_mode_e;

  typedef enum logic [3:0] {
    CRV_CONST_SPEED,
    CRV_CONST_ACCEL,
    CRV_FIFTH,
    CRV_SINGLE_HYP,
    CRV_CYCLOID,
    CRV_DIST_TRAP,
    CRV_DIST_SINE,
    CRV_DIST_CSPEED,
    CRV_TRAPECLOID,
    CRV_REV_TRAPECLOID,
    CRV_DOUBLE_HYP,
    CRV_REV_DOUBLE_HYP
  } scp_curve_e;

  localparam int CURVE_COUNT = 12;
  localparam int CURVE_PTS = 9;

  // Normalised shape of each curve at eighths of a segment, full scale 256
  localparam logic [0:CURVE_COUNT-1][0:CURVE_PTS-1][8:0] CURVE_TAB = '{
    '{9'h000, 9'h020, 9'h040, 9'h060, 9'h080, 9'h0A0, 9'h0C0, 9'h0E0, 9'h100},
    '{9'h000, 9'h008, 9'h020, 9'h048, 9'h080, 9'h0B8, 9'h0E0, 9'h0F8, 9'h100},
    '{9'h000, 9'h004, 9'h01A, 9'h046, 9'h080, 9'h0BA, 9'h0E6, 9'h0FC, 9'h100},
    '{9'h000, 9'h014, 9'h034, 9'h058, 9'h080, 9'h0A8, 9'h0CC, 9'h0EC, 9'h100},
    '{9'h000, 9'h003, 9'h017, 9'h043, 9'h080, 9'h0BD, 9'h0E9, 9'h0FD, 9'h100},
    '{9'h000, 9'h006, 9'h01E, 9'h04A, 9'h080, 9'h0B6, 9'h0E2, 9'h0FA, 9'h100},
    '{9'h000, 9'h005, 9'h01B, 9'h048, 9'h080, 9'h0B8, 9'h0E5, 9'h0FB, 9'h100},
    '{9'h000, 9'h00E, 9'h02C, 9'h056, 9'h080, 9'h0AA, 9'h0D4, 9'h0F2, 9'h100},
    '{9'h000, 9'h004, 9'h01A, 9'h046, 9'h080, 9'h0BA, 9'h0E6, 9'h0FC, 9'h100},
    '{9'h000, 9'h032, 9'h05C, 9'h070, 9'h080, 9'h090, 9'h0A4, 9'h0CE, 9'h100},
    '{9'h000, 9'h003, 9'h018, 9'h044, 9'h080, 9'h0BC, 9'h0E8, 9'h0FD, 9'h100},
    '{9'h000, 9'h03C, 9'h062, 9'h074, 9'h080, 9'h08C, 9'h09E, 9'h0C4, 9'h100}
  };

  // ==========================================================================
  // Grouped carriers
  typedef struct packed {
    scp_mode_e mode;
    logic [1:0] res_sel;
    scp_curve_e curve;
    logic src_internal;
    logic [NPTS_W-1:0] n_points;
    logic signed [31:0] stroke;
    logic signed [31:0] ref_pos;
    logic [31:0] cycle_len;
    logic [31:0] mark_target;
  } scp_cfg_s;

  typedef struct packed {
    logic we;
    logic [MEM_AW-1:0] addr;
    logic [MEM_DW-1:0] data;
  } scp_wr_s;

endpackage : scp_pkg

// >>> verilog/scp_mem.sv
// Profile memory: one write port, one read port with registered read data.
// Assumes the same clock for both ports; contents are not cleared by reset.
`timescale 1ns/10ps
`default_nettype none

module scp_mem import scp_pkg::*; #(
  parameter int DW = MEM_DW,
  parameter int AW = MEM_AW
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule : scp_mem
`default_nettype wire

// >>> verilog/scp_quad.sv
// Quadrature decoder for the synchronous encoder's A and B phases.
// Assumes raw pins: both phases pass two flip-flops before decoding.
`timescale 1ns/10ps
`default_nettype none

module scp_quad import scp_pkg::*; #(
  parameter int CNT_W = 32,
  parameter int MIN_GAP = ENC_EDGE_CYC_MIN
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Encoder pins
  input wire logic a_in,
  input wire logic b_in,
  // Results
  output logic [CNT_W-1:0] count_out,
  output logic err_out
);

  logic a1_q, a2_q, a3_q, b1_q, b2_q, b3_q;
  logic [1:0] fill_q, fill_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic err_q, err_d;
  logic edge_seen;

  // ==========================================================================
  // Decode
  always_comb begin
    fill_d = (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
    gap_d = (gap_q == '1) ? gap_q : gap_q + 1'b1;
    count_d = count_q;
    err_d = err_q;
    edge_seen = 1'b0;
    if (fill_q == 2'h3) begin
      case ({a3_q, b3_q, a2_q, b2_q})
        4'h1, 4'h7, 4'hE, 4'h8: begin
          count_d = count_q + 1'b1;
          edge_seen = 1'b1;
        end
        4'h2, 4'hB, 4'hD, 4'h4: begin
          count_d = count_q - 1'b1;
          edge_seen = 1'b1;
        end
        4'h0, 4'h5, 4'hA, 4'hF: begin
          edge_seen = 1'b0;
        end
        default: begin
          // Both phases moved in one sample: input beyond the legal rate
          err_d = 1'b1;
          edge_seen = 1'b1;
        end
      endcase
    end
    if (edge_seen) begin
      gap_d = '0;
      if (gap_q < GAP_W'(MIN_GAP - 1)) begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      a1_q <= 1'b0;
      a2_q <= 1'b0;
      a3_q <= 1'b0;
      b1_q <= 1'b0;
      b2_q <= 1'b0;
      b3_q <= 1'b0;
      fill_q <= 2'h0;
      gap_q <= '1;
      count_q <= '0;
      err_q <= 1'b0;
    end else begin
      a1_q <= a_in;
      a2_q <= a1_q;
      a3_q <= a2_q;
      b1_q <= b_in;
      b2_q <= b1_q;
      b3_q <= b2_q;
      fill_q <= fill_d;
      gap_q <= gap_d;
      count_q <= count_d;
      err_q <= err_d;
    end
  end

  assign count_out = count_q;
  assign err_out = err_q;

endmodule : scp_quad
`default_nettype wire

// >>> testbench/scp_engine_monitor.sv
// Port checker for the cam profile engine.
// Assumes one clock domain; bound into every scp_engine.
`timescale 1ns/10ps
`default_nettype none

module scp_engine_monitor import scp_pkg::*; (
  // Clock and inputs
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SERVO_ON_IN,
  input wire scp_wr_s WORK_WR_IN,
  input wire logic MARK_IN,
  // Outputs
  input wire logic signed [31:0] FEED_POS_OUT,
  input wire logic FEED_VALID_OUT,
  input wire logic BOOT_BUSY_OUT,
  input wire logic WR_REFUSED_OUT,
  input wire logic MARK_EVENT_OUT,
  input wire logic ENC_ERR_OUT,
  input wire logic [31:0] ENC_COUNT_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (SYS_RST_IN);

  // ======
  // Cycles since release, saturating
  logic [11:0] cyc_q;
  logic [11:0] cyc_d;
  always_comb cyc_d = (cyc_q == 12'hFFF) ? cyc_q : cyc_q + 12'h001;
  always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) cyc_q <= 12'h000;
    else cyc_q <= cyc_d;
  end

  sequence bad_wr_seq;
    WORK_WR_IN.we && (SERVO_ON_IN || BOOT_BUSY_OUT);
  endsequence
  sequence mark_rise_seq;
    !MARK_IN ##1 MARK_IN;
  endsequence

  wr_refuse_a: assert property (bad_wr_seq |=> WR_REFUSED_OUT)
    else $error("refused write not flagged");
  wr_cause_a: assert property (WR_REFUSED_OUT |-> $past(WORK_WR_IN.we))
    else $error("refusal without a write");
  feed_pulse_a: assert property (FEED_VALID_OUT |=> !FEED_VALID_OUT)
    else $error("valid longer than a cycle");
  feed_hold_a: assert property (!FEED_VALID_OUT |-> $stable(FEED_POS_OUT))
    else $error("feed changed without valid");
  mark_event_a: assert property (mark_rise_seq |-> ##[1:4] MARK_EVENT_OUT)
    else $error("mark edge missed");
  mark_once_a: assert property (MARK_EVENT_OUT |=> !MARK_EVENT_OUT)
    else $error("mark event too long");
  enc_step_a: assert property ((ENC_COUNT_OUT - $past(ENC_COUNT_OUT))
    inside {32'h0, 32'h1, 32'hFFFFFFFF})
    else $error("count jumped");
  enc_sticky_a: assert property (ENC_ERR_OUT |=> ENC_ERR_OUT)
    else $error("encoder error dropped");
  boot_busy_a: assert property (cyc_q <= 12'(MEM_WORDS) |-> BOOT_BUSY_OUT)
    else $error("copy ended early");
  boot_done_a: assert property (cyc_q > 12'(MEM_WORDS) |-> !BOOT_BUSY_OUT)
    else $error("copy ended late");
endmodule : scp_engine_monitor

bind scp_engine scp_engine_monitor i_scp_engine_monitor (.CLOCK_IN(CLOCK_IN),
  .SYS_RST_IN(SYS_RST_IN), .SERVO_ON_IN(SERVO_ON_IN), .WORK_WR_IN(WORK_WR_IN),
  .MARK_IN(MARK_IN), .FEED_POS_OUT(FEED_POS_OUT), .FEED_VALID_OUT(FEED_VALID_OUT),
  .BOOT_BUSY_OUT(BOOT_BUSY_OUT), .WR_REFUSED_OUT(WR_REFUSED_OUT),
  .MARK_EVENT_OUT(MARK_EVENT_OUT), .ENC_ERR_OUT(ENC_ERR_OUT),
  .ENC_COUNT_OUT(ENC_COUNT_OUT));

`default_nettype wire

// >>> testbench/scp_enc_model.sv
// Synchronous encoder and mark sensor model.
// Assumes the bench calls its tasks; pins move at falling edges.
`timescale 1ns/10ps
`default_nettype none

module scp_enc_model (
  // Clock
  input wire logic clk_in,
  // Pins
  output logic a_out,
  output logic b_out,
  output logic mark_out
);
  logic [1:0] ph = 2'h0;
  initial begin
    a_out = 1'b0;
    b_out = 1'b0;
    mark_out = 1'b0;
  end

  // Gray order 00,01,11,10 counts up; a gap under 3 cycles is too fast
  task automatic steps(input int n, input bit up, input int gap);
    repeat (n) begin
      repeat (gap) @(negedge clk_in);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      {a_out, b_out} = {ph[1], ph[1] ^ ph[0]};
    end
  endtask : steps

  task automatic mark_pulse(input int len);
    @(negedge clk_in);
    mark_out = 1'b1;
    repeat (len) @(negedge clk_in);
    mark_out = 1'b0;
  endtask : mark_pulse
endmodule : scp_enc_model

`default_nettype wire

// >>> testbench/scp_engine_tb.sv
// Self-checking bench for the cam profile engine.
// Assumes the bound checker and the encoder model beside it.
`timescale 1ns/10ps
`default_nettype none

module scp_engine_tb import scp_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic servo = 1'b0;
  logic [31:0] cmd = 32'h0;
  scp_cfg_s cfg = '0;
  scp_wr_s wwr = '0;
  scp_wr_s swr = '0;
  logic enc_a, enc_b, mark, valid, busy, refused, mevt, eerr;
  logic signed [31:0] feed, comp;
  logic [31:0] cpos, ecnt;
  int error_cnt = 0;
  int samples_checked = 0;
  int ref_n = 0;
  int mk_n = 0;
  int cyc = 0;

  scp_engine i_scp_engine (.CLOCK_IN(clk), .SYS_RST_IN(rst), .CAM_CFG_IN(cfg),
    .CMD_POS_IN(cmd), .SERVO_ON_IN(servo), .WORK_WR_IN(wwr), .STORE_WR_IN(swr),
    .ENC_A_IN(enc_a), .ENC_B_IN(enc_b), .MARK_IN(mark), .FEED_POS_OUT(feed),
    .FEED_VALID_OUT(valid), .CYCLE_POS_OUT(cpos), .BOOT_BUSY_OUT(busy),
    .WR_REFUSED_OUT(refused), .MARK_EVENT_OUT(mevt), .MARK_COMP_OUT(comp),
    .ENC_ERR_OUT(eerr), .ENC_COUNT_OUT(ecnt));
  scp_enc_model i_scp_enc_model (.clk_in(clk), .a_out(enc_a), .b_out(enc_b),
    .mark_out(mark));

  always #10 clk = ~clk;
  // Sampled mid-cycle so registered pulses are settled
  always @(negedge clk) begin
    ref_n += refused;
    mk_n += mevt;
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (2060) @(negedge clk);
    chk("busy", busy, 32'h0);
  endtask : do_reset

  task automatic fill(input logic [31:0] d);
    for (int i = 0; i < 2048; i++) begin
      @(negedge clk);
      wwr = '{1'b1, i[10:0], d};
    end
    @(negedge clk);
    wwr.we = 1'b0;
  endtask : fill

  // Second result is the first run wholly under the new inputs
  task automatic feed_chk(input logic [31:0] exp);
    int n;
    n = 0;
    repeat (2) begin
      @(posedge clk);
      #1;
      while (valid !== 1'b1 && n < 900) begin
        @(posedge clk);
        #1;
        n++;
      end
    end
    chk("feed", feed, exp);
    @(negedge clk);
  endtask : feed_chk

  function automatic int cexp(input int r, input int o, input int sh);
    return r + int'((longint'(o) * sh) / 256);
  endfunction : cexp

  initial begin
    int rp, o1, st, k, tg, n;
    void'($urandom(39));
    do_reset();
    o1 = $urandom % 999999;
    rp = $urandom % 100000;
    // Points (0,0) and (1000,o1) go to storage, loaded by a second reset
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      swr = '{1'b1, i[10:0], (i == 3) ? o1 : (i == 2) ? 32'h3E8 : 32'h0};
    end
    @(negedge clk);
    swr.we = 1'b0;
    do_reset();
    cfg.mode = MODE_COORD;
    cfg.n_points = 11'h002;
    cfg.src_internal = 1'b1;
    cfg.ref_pos = rp;
    cfg.cycle_len = 32'h186A0;
    cmd = 32'hFA;
    for (int c = 0; c < CURVE_COUNT; c++) begin
      cfg.curve = scp_curve_e'(c);
      feed_chk(cexp(rp, o1, CURVE_TAB[c][2]));
    end
    cmd = 32'h1F4;
    feed_chk(cexp(rp, o1, 128));
    chk("cycle", cpos, 32'h1F4);
    cmd = 32'h7D0;
    feed_chk(cexp(rp, o1, 256));
    st = $urandom % 10000;
    k = $urandom % 101;
    cfg.mode = MODE_STROKE;
    cfg.stroke = st;
    fill(k * 1000);
    for (int r = 0; r <= RES_SEL_MAX; r++) begin
      cfg.res_sel = r[1:0];
      feed_chk(rp + st * k / 100);
    end
    fill(32'h249F0);
    feed_chk(rp + st);
    servo = 1'b1;
    tg = ref_n;
    fill(32'h0);
    servo = 1'b0;
    feed_chk(rp + st);
    chk("refused", ref_n - tg, 32'h800);
    tg = $urandom % 100000;
    cfg.mark_target = tg;
    i_scp_enc_model.mark_pulse(10);
    feed_chk(rp + st + tg - 2000);
    chk("comp", comp, tg - 2000);
    chk("mark_evt", mk_n, 32'h1);
    cfg.src_internal = 1'b0;
    n = $urandom % 20 + 5;
    i_scp_enc_model.steps(n, 1'b1, 5);
    i_scp_enc_model.steps(3, 1'b0, 5);
    repeat (5) @(negedge clk);
    chk("count", ecnt, n - 3);
    chk("cycle", cpos, n - 3);
    chk("enc_err", eerr, 32'h0);
    i_scp_enc_model.steps(4, 1'b1, 1);
    repeat (5) @(negedge clk);
    chk("enc_err", eerr, 32'h1);
    conclude();
  end
endmodule : scp_engine_tb

`default_nettype wire
